/* ddr_cmd_core.sv */
// command decode, bank tracking, write burst storage and power states
// assumes the controller keeps all timing on its side; inputs synchronous
// Overview of operation
// RULE_01 - controller times turnaround from last pair
// RULE_02 - odd data times from full pair end
// RULE_03 - write recovery measured from last pair
// RULE_04 - turnaround applies across all banks
// RULE_05 - read cuts write; earlier elements stored
// RULE_06 - new write truncates burst, any bank
// RULE_07 - burst columns follow programmed order
// RULE_08 - autoprecharge bit low keeps row open
// RULE_09 - strobe may stop after precharge cut
// RULE_10 - controller waits after mode set
// RULE_11 - refreshes may follow first mode set
// RULE_12 - no power-down during column access
// RULE_13 - idle banks precharge, open rows active
// RULE_14 - precharge all banks before refresh
// RULE_15 - data lines ignored during refresh
// RULE_16 - self refresh only when banks idle
// RULE_17 - controller waits after self refresh exit
// RULE_18 - precharge only after row active time
// RULE_19 - read autoprecharge waits minimum delay
// RULE_20 - two refreshes before final mode set
// RULE_21 - extra cycles after loop reset
// RULE_22 - decode one command per enabled edge
`timescale 1ns/1ps
module ddr_cmd_core #(
    parameter int BANKS = ddr_cmd_pkg::NUM_BANKS
) (
    // clock and reset
    input  wire logic                            CLOCK,
    input  wire logic                            RST,
    // command side
    input  wire logic                            CKE,
    input  wire ddr_cmd_pkg::cmd_bus_t           CMD,
    // write data, one element per cycle
    input  wire ddr_cmd_pkg::wr_beat_t           WR_BEAT,
    // read data
    output logic [ddr_cmd_pkg::DATA_W-1:0]       RD_DATA,
    output logic                                 RD_VALID,
    // state
    output logic [BANKS-1:0]                     BANK_OPEN,
    output ddr_cmd_pkg::pwr_state_t              PWR_STATE
);
    localparam int AW = ddr_cmd_pkg::MEM_DEPTH_W;
    localparam int CW = ddr_cmd_pkg::COL_W;

    logic                          cke_q_r;
    logic [ddr_cmd_pkg::ROW_W-1:0] row_r [BANKS];
    logic [BANKS-1:0]              open_r;
    logic [BANKS-1:0]              ap_pend_r;
    logic [3:0]                    bl_r;
    logic                          bt_r;
    logic                          wr_act_r;
    logic [3:0]                    wr_left_r;
    logic [3:0]                    wr_idx_r;
    logic [ddr_cmd_pkg::BANK_W-1:0] wr_bank_r;
    logic [CW-1:0]                 wr_col_r;
    logic                          wr_ap_r;
    logic                          rd_act_r;
    logic [3:0]                    rd_left_r;
    logic [CW-1:0]                 rd_col_r;
    logic                          rd_vld_r;
    logic [AW-1:0]                 rd_addr_r;
    ddr_cmd_pkg::pwr_state_t       pwr_r;
    ddr_cmd_pkg::pwr_state_t       pwr_nxt;
    logic                          cmd_ok;
    logic                          is_wr;
    logic                          is_rd;
    logic [CW-1:0]                 wcol;
    logic [AW-1:0]                 waddr;
    logic                          st_we;

    // commands are only seen on edges where the clock enable was high
    assign cmd_ok = CKE && cke_q_r &&
                    pwr_r == ddr_cmd_pkg::PWR_ACTIVE;        // RULE_22
    assign is_wr  = cmd_ok && CMD.code == ddr_cmd_pkg::CMD_WRITE;
    assign is_rd  = cmd_ok && CMD.code == ddr_cmd_pkg::CMD_READ;

    // burst column: sequential adds in the burst window, interleave xors
    function automatic logic [CW-1:0] burst_col(
        input logic [CW-1:0] base,
        input logic [3:0]    idx,
        input logic [3:0]    bl,
        input logic          inter
    );
        logic [CW-1:0] msk;
        logic [CW-1:0] ofs;
        msk = CW'(bl) - CW'(1);
        ofs = inter ? ((base ^ CW'(idx)) & msk)
                    : ((base + CW'(idx)) & msk);
        burst_col = (base & ~msk) | ofs;
    endfunction

    assign wcol  = burst_col(wr_col_r, wr_idx_r, bl_r, bt_r);  // RULE_07
    assign waddr = {wr_bank_r, row_r[wr_bank_r], wcol};
    // refresh and idle cycles never store: beats only count in a burst
    assign st_we = wr_act_r && WR_BEAT.valid;                   // RULE_15

    // previous clock enable, for power-down entry detection and command gating
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cke_q_r <= 1'b0;
        end else begin
            cke_q_r <= CKE;
        end
    end

    // mode register: burst length and type, other fields ignored here
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            bl_r <= ddr_cmd_pkg::BL_FOUR;
            bt_r <= 1'b0;
        end else if (cmd_ok && CMD.code == ddr_cmd_pkg::CMD_MRS &&
                     CMD.bank == '0) begin
            unique case (CMD.addr[2:0])
                3'h1:    bl_r <= ddr_cmd_pkg::BL_TWO;
                3'h3:    bl_r <= ddr_cmd_pkg::BL_EIGHT;
                default: bl_r <= ddr_cmd_pkg::BL_FOUR;
            endcase
            bt_r <= CMD.addr[ddr_cmd_pkg::BT_FIELD];
        end
    end

    // bank rows: activate opens, precharge closes, ap closes at burst end
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            open_r    <= '0;
            ap_pend_r <= '0;
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                if (cmd_ok && CMD.code == ddr_cmd_pkg::CMD_ACT &&
                    CMD.bank == b[ddr_cmd_pkg::BANK_W-1:0]) begin
                    open_r[b] <= 1'b1;
                    row_r[b]  <= CMD.addr;
                end
                if (cmd_ok && CMD.code == ddr_cmd_pkg::CMD_PRE &&
                    (CMD.addr[ddr_cmd_pkg::AP_BIT] ||
                     CMD.bank == b[ddr_cmd_pkg::BANK_W-1:0])) begin
                    open_r[b] <= 1'b0;                       // RULE_14
                end
                // bit low: no automatic close, row stays open
                if ((is_wr || is_rd) &&
                    CMD.bank == b[ddr_cmd_pkg::BANK_W-1:0]) begin
                    ap_pend_r[b] <= CMD.addr[ddr_cmd_pkg::AP_BIT]; // RULE_08
                end
                if (ap_pend_r[b] && !wr_act_r && !rd_act_r &&
                    !(is_wr || is_rd)) begin
                    ap_pend_r[b] <= 1'b0;
                    open_r[b]    <= 1'b0;
                end
            end
        end
    end

    // write burst: a new write or a read cuts the old one short
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_act_r  <= 1'b0;
            wr_left_r <= '0;
            wr_idx_r  <= '0;
            wr_bank_r <= '0;
            wr_col_r  <= '0;
        end else if (is_wr) begin
            wr_act_r  <= 1'b1;                               // RULE_06
            wr_left_r <= bl_r;
            wr_idx_r  <= '0;
            wr_bank_r <= CMD.bank;
            wr_col_r  <= CMD.addr[CW-1:0];
        end else if (is_rd ||
                     (cmd_ok && CMD.code == ddr_cmd_pkg::CMD_PRE)) begin
            wr_act_r  <= 1'b0;                               // RULE_05
            wr_left_r <= '0;
        end else if (st_we) begin
            wr_idx_r  <= wr_idx_r + 4'h1;
            wr_left_r <= wr_left_r - 4'h1;
            wr_act_r  <= wr_left_r != 4'h1;
        end
    end

    // read burst from the array; burst stop ends it
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rd_act_r  <= 1'b0;
            rd_left_r <= '0;
            rd_vld_r  <= 1'b0;
            rd_addr_r <= '0;
            rd_col_r  <= '0;
        end else begin
            rd_vld_r <= rd_act_r;
            if (is_rd) begin
                rd_act_r  <= 1'b1;
                rd_left_r <= bl_r;
                rd_addr_r <= {CMD.bank, row_r[CMD.bank],
                              CMD.addr[CW-1:0]};
                rd_col_r  <= CMD.addr[CW-1:0];
            end else if (is_wr || (cmd_ok &&
                         CMD.code == ddr_cmd_pkg::CMD_BST)) begin
                rd_act_r <= 1'b0;
            end else if (rd_act_r) begin
                rd_left_r <= rd_left_r - 4'h1;
                rd_act_r  <= rd_left_r != 4'h1;
                // later elements wrap inside the burst window, like writes
                rd_addr_r[CW-1:0] <= burst_col(rd_col_r,
                    bl_r - rd_left_r + 4'h1, bl_r, bt_r);   // RULE_07
            end
        end
    end

    ddr_store #(
        .AW (AW),
        .DW (ddr_cmd_pkg::DATA_W)
    ) u_store (
        .clk   (CLOCK),
        .we    (st_we),
        .be    (~WR_BEAT.mask),
        .waddr (waddr),
        .wdata (WR_BEAT.data),
        .raddr (rd_addr_r),
        .rdata (RD_DATA)
    );

    // power state: kind of power-down picked from bank state at entry
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            ddr_cmd_pkg::PWR_ACTIVE: begin
                if (cke_q_r && !CKE && CMD.code == ddr_cmd_pkg::CMD_REF) begin
                    pwr_nxt = ddr_cmd_pkg::PWR_SELF_REF;    // RULE_16
                end else if (cke_q_r && !CKE) begin
                    pwr_nxt = (open_r == '0)
                            ? ddr_cmd_pkg::PWR_PRE_PD
                            : ddr_cmd_pkg::PWR_ACT_PD;      // RULE_13
                end
            end
            ddr_cmd_pkg::PWR_PRE_PD,
            ddr_cmd_pkg::PWR_ACT_PD,
            ddr_cmd_pkg::PWR_SELF_REF: begin
                if (CKE) begin
                    pwr_nxt = ddr_cmd_pkg::PWR_ACTIVE;
                end
            end
            default: pwr_nxt = ddr_cmd_pkg::PWR_ACTIVE;
        endcase
    end

    // power state register
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pwr_r <= ddr_cmd_pkg::PWR_ACTIVE;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    assign RD_VALID  = rd_vld_r;
    assign BANK_OPEN = open_r;
    assign PWR_STATE = pwr_r;

    // checks
    a_pd_kind_idle: assert property (@(posedge CLOCK) disable iff (RST)
        pwr_r == ddr_cmd_pkg::PWR_ACTIVE && cke_q_r && !CKE &&
        CMD.code != ddr_cmd_pkg::CMD_REF && open_r == '0
        |=> pwr_r == ddr_cmd_pkg::PWR_PRE_PD) // RULE_13
        else $error("idle entry not precharge power-down");
    a_pd_kind_open: assert property (@(posedge CLOCK) disable iff (RST)
        pwr_r == ddr_cmd_pkg::PWR_ACTIVE && cke_q_r && !CKE &&
        CMD.code != ddr_cmd_pkg::CMD_REF && open_r != '0
        |=> pwr_r == ddr_cmd_pkg::PWR_ACT_PD) // RULE_13
        else $error("open row entry not active power-down");
    a_wr_truncate: assert property (@(posedge CLOCK) disable iff (RST)
        is_wr |=> wr_act_r && wr_idx_r == '0 && wr_left_r == bl_r) // RULE_06
        else $error("new write did not restart burst");
    a_rd_cuts_wr: assert property (@(posedge CLOCK) disable iff (RST)
        is_rd |=> !wr_act_r ##1 !st_we) // RULE_05
        else $error("write continued after read");
    a_no_ap_open: assert property (@(posedge CLOCK) disable iff (RST)
        is_wr && !CMD.addr[ddr_cmd_pkg::AP_BIT] && open_r[CMD.bank]
        ##1 (cmd_ok == 1'b0 || CMD.code == ddr_cmd_pkg::CMD_NOP)
        |=> open_r[$past(CMD.bank, 2)]) // RULE_08
        else $error("row closed without precharge");
    a_first_col: assert property (@(posedge CLOCK) disable iff (RST)
        is_wr ##1 st_we |-> waddr[CW-1:0] == $past(CMD.addr[CW-1:0])) // RULE_07
        else $error("first element not at addressed column");
    a_cke_decode: assert property (@(posedge CLOCK) disable iff (RST)
        !CKE |-> !is_wr && !is_rd) // RULE_22
        else $error("command decoded with clock enable low");
    a_ref_no_store: assert property (@(posedge CLOCK) disable iff (RST)
        st_we |-> wr_left_r != '0 && wr_idx_r < bl_r) // RULE_15
        else $error("store outside write burst");
    c_wr_burst:  cover property (@(posedge CLOCK) is_wr ##1 st_we[*4]);
    c_wr_to_rd:  cover property (@(posedge CLOCK) is_wr ##2 is_rd);
    c_self_ref:  cover property (@(posedge CLOCK)
        pwr_r == ddr_cmd_pkg::PWR_SELF_REF);
    c_act_pd:    cover property (@(posedge CLOCK)
        pwr_r == ddr_cmd_pkg::PWR_ACT_PD);
endmodule

/* ddr_cmd_pkg.sv */
// shared types and constants for the ddr command/timing core
// assumes one 125 MHz clock and a synchronous controller on the far side
package ddr_cmd_pkg;
    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int ROW_W      = 12;
    localparam int COL_W      = 9;
    localparam int DATA_W     = 16;
    localparam int MASK_W     = 2;
    localparam int ADDR_W     = 12;
    localparam int AP_BIT     = 10;
    localparam int BL_W       = 4;
    localparam int CNT_W      = 4;
    localparam logic [3:0] BL_TWO   = 4'h2;
    localparam logic [3:0] BL_FOUR  = 4'h4;
    localparam logic [3:0] BL_EIGHT = 4'h8;
    localparam logic [2:0] BL_RESET_CODE = 3'h2;
    localparam int BL_FIELD_LO = 0;
    localparam int BT_FIELD    = 3;
    localparam int MEM_DEPTH_W = BANK_W + ROW_W + COL_W;

    // command encoding: {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_MRS   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WRITE = 4'h4,
        CMD_READ  = 4'h5,
        CMD_BST   = 4'h6,
        CMD_NOP   = 4'h7
    } cmd_code_t;

    typedef struct packed {
        cmd_code_t          code;
        logic [BANK_W-1:0]  bank;
        logic [ADDR_W-1:0]  addr;
    } cmd_bus_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic [MASK_W-1:0] mask; // {upper_byte_mask, lower_byte_mask}
    } wr_beat_t;

    typedef enum logic [3:0] {
        PWR_ACTIVE   = 4'b0001,
        PWR_PRE_PD   = 4'b0010,
        PWR_ACT_PD   = 4'b0100,
        PWR_SELF_REF = 4'b1000
    } pwr_state_t;
endpackage

/* ddr_store.sv */
// little storage array for the written elements, registered read data
// assumes one clock; write and read may happen in the same cycle
`timescale 1ns/1ps
module ddr_store #(
    parameter int AW = 23,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [1:0]    be,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // byte lanes follow the masks, high bit guards the upper byte
    always_ff @(posedge clk) begin
        if (we && be[0]) begin
            mem[waddr][7:0] <= wdata[7:0];
        end
        if (we && be[1]) begin
            mem[waddr][15:8] <= wdata[15:8];
        end
    end

    // read data comes from a flop
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

/* ddr_ctrl_model.sv */
// controller model: commands, write elements and clock enable
// assumes one caller process; drives 1 ns after each rising edge
`timescale 1ns/1ps
module ddr_ctrl_model #(
    parameter int RAS = 6, // min_row_active_time, clocks
    parameter int MRD = 2, // mode_set_delay, clocks
    parameter int RFC = 9, // refresh_cycle_time, clocks
    parameter int WRC = 2  // write recovery and turnaround, clocks
) (
    // clock
    input  wire logic             clk,
    // controller side
    output logic                  cke,
    output ddr_cmd_pkg::cmd_bus_t cmd,
    output ddr_cmd_pkg::wr_beat_t beat
);
    initial begin
        cke = 1'b1;
        cmd = '{ddr_cmd_pkg::CMD_NOP, 2'h0, 12'h000};
        beat = '0;
    end
    // idle lines toggle so stale values never pass for live ones
    task automatic step(input ddr_cmd_pkg::cmd_code_t c,
                        input logic [13:0] ba, input logic v,
                        input logic [17:0] dm);
        @(posedge clk);
        #1;
        cmd.code = c;
        {cmd.bank, cmd.addr} = (c == ddr_cmd_pkg::CMD_NOP) ?
            ~{cmd.bank, cmd.addr} : ba;
        beat.valid = v;
        {beat.data, beat.mask} = v ? dm : ~{beat.data, beat.mask};
    endtask
    task automatic nops(input int n);
        repeat (n) step(ddr_cmd_pkg::CMD_NOP, 14'h0000, 1'b0, 18'h0_0000);
    endtask
    task automatic one(input ddr_cmd_pkg::cmd_code_t c,
                       input logic [13:0] ba);
        step(c, ba, 1'b0, 18'h0_0000);
        nops(1);
    endtask
    task automatic act(input logic [13:0] ba);
        one(ddr_cmd_pkg::CMD_ACT, ba);
        nops(2);
    endtask
    task automatic mode_register_set_cmd(input logic [1:0] b, input logic [11:0] a);
        one(ddr_cmd_pkg::CMD_MRS, {b, a});
        nops(MRD);
    endtask
    task automatic pre_all();
        nops(RAS);
        one(ddr_cmd_pkg::CMD_PRE, 14'h0400);
    endtask
    // junk strobes during refresh show that data lines are ignored
    task automatic refresh(input logic junk);
        one(ddr_cmd_pkg::CMD_REF, 14'h0000);
        repeat (RFC) step(ddr_cmd_pkg::CMD_NOP, 14'h0000, junk,
                          18'h1_5A5A);
    endtask
    task automatic init();
        pre_all();
        mode_register_set_cmd(2'h1, 12'h000);
        mode_register_set_cmd(2'h0, 12'h102);
        nops(200);
        pre_all();
        refresh(1'b0);
        refresh(1'b0);
        mode_register_set_cmd(2'h0, 12'h002);
    endtask
    // odd counts wait out the whole pair; lines released after a cut
    task automatic write(input logic [1:0] b, input logic [8:0] c,
                         input logic ap, input int n,
                         input logic [17:0] dm [8]);
        step(ddr_cmd_pkg::CMD_WRITE, {b, 1'b0, ap, 1'b0, c}, 1'b0,
             18'h0_0000);
        for (int i = 0; i < n; i++)
            step(ddr_cmd_pkg::CMD_NOP, 14'h0000, 1'b1, dm[i]);
        nops(WRC + n % 2);
    endtask
    task automatic read(input logic [1:0] b, input logic [8:0] c,
                        input logic ap);
        if (ap)
            nops(RAS);
        one(ddr_cmd_pkg::CMD_READ, {b, 1'b0, ap, 1'b0, c});
    endtask
    // power-down only once column accesses have drained
    task automatic cke_low(input logic self);
        nops(4);
        @(posedge clk);
        #1;
        cke = 1'b0;
        cmd.code = self ? ddr_cmd_pkg::CMD_REF : ddr_cmd_pkg::CMD_NOP;
        nops(3);
    endtask
    task automatic cke_high();
        @(posedge clk);
        #1;
        cke = 1'b1;
        nops(200);
    endtask
endmodule

/* test_ddr_sdram_command_timing.sv */
// self-checking bench: random and corner traffic through the core
// assumes the controller model keeps all timing on the far side
`timescale 1ns/1ps
module test_ddr_sdram_command_timing;
    logic                    clock;
    logic                    rst;
    logic                    cke;
    ddr_cmd_pkg::cmd_bus_t   cmd;
    ddr_cmd_pkg::wr_beat_t   beat;
    logic [15:0]             rd_data;
    logic                    rd_valid;
    logic [3:0]              bank_open;
    ddr_cmd_pkg::pwr_state_t pwr_state;
    int                      failures;
    int                      tests_run;
    int                      seed;
    logic [15:0]             shadow [int];
    logic [11:0]             row_of [4];
    logic [17:0]             dm [8];
    logic [3:0]              bl;
    logic                    inter;
    logic [1:0]              b_r;
    logic [8:0]              c_r;

    ddr_cmd_core dut (.CLOCK(clock), .RST(rst), .CKE(cke), .CMD(cmd),
        .WR_BEAT(beat), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .BANK_OPEN(bank_open), .PWR_STATE(pwr_state));
    ddr_ctrl_model ctl (.clk(clock), .cke(cke), .cmd(cmd), .beat(beat));

    always #4 clock = ~clock;

    // column of element i in the current burst order
    function automatic logic [8:0] col_at(input logic [8:0] c, input int i);
        logic [8:0] w;
        w = 9'(bl - 4'h1);
        return (c & ~w) | ((inter ? (c ^ 9'(i)) : (c + 9'(i))) & w);
    endfunction
    function automatic int key(input logic [1:0] b, input logic [8:0] c);
        return int'({b, row_of[b], c});
    endfunction
    // a set mask bit keeps the old byte
    function automatic logic [15:0] merge(input logic [15:0] o,
                                          input logic [17:0] e);
        return {e[1] ? o[15:8] : e[17:10], e[0] ? o[7:0] : e[9:2]};
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_st(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // masks only on places already written, else old bytes are unknown
    task automatic do_write(input logic [1:0] b, input logic [8:0] c,
                            input logic ap, input int n, input logic msk);
        int k;
        for (int i = 0; i < 8; i++) begin
            dm[i] = {16'($random(seed)), msk ? 2'($random(seed)) : 2'h0};
            k = key(b, col_at(c, i));
            if (i < n)
                shadow[k] = merge(shadow.exists(k) ? shadow[k] : 16'h0000,
                                  dm[i]);
        end
        ctl.write(b, c, ap, n, dm);
    endtask
    task automatic do_read(input logic [1:0] b, input logic [8:0] c);
        int n;
        ctl.read(b, c, 1'b0);
        n = 0;
        @(negedge clock);
        while (rd_valid !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        for (int i = 0; i < bl; i++) begin
            chk_st({3'b000, rd_valid}, 4'h1);
            chk16(rd_data, shadow[key(b, col_at(c, i))]);
            @(negedge clock);
        end
        chk_st({3'b000, rd_valid}, 4'h0);
    endtask
    // modes change only with all banks idle; rows reopened after
    task automatic set_mode(input logic [2:0] code, input logic il);
        ctl.pre_all();
        ctl.mode_register_set_cmd(2'h0, {8'h00, il, code});
        bl = (code == 3'h1) ? 4'h2 : ((code == 3'h3) ? 4'h8 : 4'h4);
        inter = il;
        for (int b = 0; b < 4; b++)
            ctl.act({2'(b), row_of[b]});
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog; the sequence needs about 1400 clocks
    initial begin
        repeat (40000) @(posedge clock);
        failures++;
        close_out();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        seed = 40;
        failures = 0;
        tests_run = 0;
        bl = 4'h4;
        inter = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
        chk_st(pwr_state, ddr_cmd_pkg::PWR_ACTIVE);
        chk_st(bank_open, 4'h0);
        ctl.init();
        for (int b = 0; b < 4; b++)
            row_of[b] = 12'($random(seed));
        set_mode(3'h3, 1'b0);
        chk_st(bank_open, 4'hF);
        for (int b = 0; b < 4; b++) begin
            do_write(2'(b), 9'h000, 1'b0, 8, 1'b0);
            do_read(2'(b), 9'h000);
        end
        $display("test fill done");
        do_write(2'h1, 9'h000, 1'b0, 2, 1'b1);
        do_read(2'h1, 9'h000);
        do_write(2'h0, 9'h004, 1'b0, 1, 1'b1);
        do_write(2'h2, 9'h003, 1'b0, 3, 1'b1);
        do_read(2'h0, 9'h000);
        do_read(2'h2, 9'h000);
        $display("test burst cuts done");
        for (int k = 0; k < 6; k++) begin
            set_mode(3'(k % 3 + 1), k >= 3);
            b_r = 2'($random(seed));
            c_r = 9'($random(seed)) & 9'h007;
            do_write(b_r, c_r, 1'b0, int'(bl), 1'b1);
            do_read(b_r, 9'($random(seed)) & 9'h007);
        end
        $display("test burst orders done");
        chk_st(bank_open, 4'hF);
        do_write(2'h3, 9'h000, 1'b1, int'(bl), 1'b0);
        ctl.nops(4);
        chk_st(bank_open, 4'h7);
        ctl.cke_low(1'b0);
        chk_st(pwr_state, ddr_cmd_pkg::PWR_ACT_PD);
        ctl.cke_high();
        ctl.pre_all();
        chk_st(bank_open, 4'h0);
        ctl.cke_low(1'b0);
        chk_st(pwr_state, ddr_cmd_pkg::PWR_PRE_PD);
        ctl.cke_high();
        chk_st(pwr_state, ddr_cmd_pkg::PWR_ACTIVE);
        $display("test power-down done");
        ctl.refresh(1'b1);
        ctl.act({2'h1, row_of[1]});
        do_read(2'h1, 9'h000);
        ctl.pre_all();
        ctl.cke_low(1'b1);
        chk_st(pwr_state, ddr_cmd_pkg::PWR_SELF_REF);
        ctl.act({2'h2, row_of[2]});
        chk_st(bank_open, 4'h0);
        ctl.cke_high();
        chk_st(pwr_state, ddr_cmd_pkg::PWR_ACTIVE);
        ctl.act({2'h2, row_of[2]});
        do_read(2'h2, 9'h000);
        ctl.read(2'h2, 9'h000, 1'b1);
        ctl.nops(12);
        chk_st(bank_open, 4'h0);
        $display("test refresh done");
        close_out();
    end
endmodule
